// file: verilog/irq_status_defines.svh
// Offsets, bit positions, reset values and thresholds for the interrupt
// status collector.
// Assumes it is included by bare name wherever these constants are used.
`ifndef IRQ_STATUS_DEFINES_SVH
`define IRQ_STATUS_DEFINES_SVH

`define STATUS_OFFSET 8'h58
`define BYTE_TEST_OFFSET 8'h64
`define STATUS_RESET 32'h0000_0000
`define RESERVED_MASK 32'h7c40_1820
`define WRITE_CLEAR_MASK 32'h83bb_e7df
`define BIT_SW 31
`define BIT_TX_HALT 25
`define BIT_RX_HALT 24
`define BIT_DROP_MID 23
`define BIT_TX_DONE 21
`define BIT_RX_DMA 20
`define BIT_TIMER 19
`define BIT_PHY 18
`define BIT_POWER 17
`define BIT_TX_SO 16
`define BIT_OVERSIZE 15
`define BIT_RX_ERR 14
`define BIT_TX_ERR 13
`define BIT_TX_OVERRUN 10
`define BIT_TX_AVAIL 9
`define BIT_TS_FULL 8
`define BIT_TS_LEVEL 7
`define BIT_RX_DROP 6
`define BIT_RS_FULL 4
`define BIT_RS_LEVEL 3
`define OVERSIZE_BYTES 16'h0800
`define TIMER_TOP 16'hffff
`define TIMER_ZERO 16'h0000

`endif

// file: verilog/irq_status_pkg.sv
// Types shared by the interrupt status collector and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package irq_status_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic software_event_enable;
        logic tx_stop_req;
        logic tx_halted;
        logic rx_halted;
        logic [31:0] drop_count;
        logic tx_load_done;
        logic completion_notify_flag;
        logic rx_dma_done;
        logic [15:0] timer_value;
        logic phy_event;
        logic power_event;
        logic tx_status_overflow;
        logic rx_frame_end;
        logic [15:0] rx_frame_bytes;
        logic rx_error;
        logic tx_error;
        logic tx_data_write;
        logic tx_data_full;
        logic [7:0] tx_free_blocks;
        logic [7:0] tx_avail_level;
        logic tx_status_full;
        logic rx_status_full;
        logic [7:0] tx_status_used;
        logic [7:0] tx_status_level;
        logic [7:0] rx_status_used;
        logic [7:0] rx_status_level;
        logic frame_dropped;
        logic [2:0] pin_events;
    } event_in_type;

endpackage

`default_nettype wire

// file: verilog/ethernet_irq_status_collector.sv
// Interrupt status collector: latches engine, FIFO, timer and pin events
// into one host-visible status word with write-one-to-clear access.
// Assumes all event inputs are synchronous to clk and that the host port
// presents one request per cycle, already decoded from the parallel bus.
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_defines.svh"

module ethernet_irq_status_collector
    import irq_status_pkg::*;
(
    input wire logic clk,                    // System clock, 20 MHz.
    input wire logic nrst,                   // Asynchronous reset, low.
    input wire host_req_type host_req,       // Host register request.
    input wire event_in_type src,            // Event sources.
    output logic [31:0] host_rdata,          // Read data, one cycle late.
    output logic [31:0] interrupt_status,    // Live status word.
    output logic wake_request                // Wake pulse on byte test write.
);

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------

    logic status_wr;
    logic status_rd;
    logic wake_wr;
    logic [31:0] clear_bits;

    assign status_wr = host_req.wr && (host_req.addr == `STATUS_OFFSET);
    assign status_rd = host_req.rd && (host_req.addr == `STATUS_OFFSET);
    assign wake_wr = host_req.wr && (host_req.addr == `BYTE_TEST_OFFSET);

    // Zero bits leave flags alone; reserved and mirror bits never clear.
    assign clear_bits = status_wr ?
        (host_req.wdata & `WRITE_CLEAR_MASK) : 32'h0000_0000;

    // ------------------------------------------------------------
    // Level conditions and their rising edges
    // ------------------------------------------------------------

    // Level sources would re-arm a cleared flag every cycle, so each
    // sets its flag only on the edge where the condition becomes true.
    logic [8:0] cond;
    logic [8:0] cond_q;
    logic [8:0] rise;
    logic [15:0] timer_q;

    assign cond[0] = src.software_event_enable;
    assign cond[1] = src.tx_stop_req && src.tx_halted;
    assign cond[2] = src.rx_halted;
    assign cond[3] = src.drop_count[31];
    assign cond[4] = src.tx_status_full;
    assign cond[5] = src.rx_status_full;
    // Both sides of each comparison share one unit; exceeding fires.
    assign cond[6] = src.tx_free_blocks > src.tx_avail_level;
    assign cond[7] = src.tx_status_used > src.tx_status_level;
    assign cond[8] = src.rx_status_used > src.rx_status_level;
    assign rise = cond & ~cond_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cond_q <= 9'h000;
        end else begin
            cond_q <= cond;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_q <= 16'h0000;
        end else begin
            timer_q <= src.timer_value;
        end
    end

    // ------------------------------------------------------------
    // Event vector
    // ------------------------------------------------------------

    logic [31:0] set_bits;
    logic timer_wrap;
    logic oversize;

    assign timer_wrap = (timer_q == `TIMER_ZERO) &&
        (src.timer_value == `TIMER_TOP);
    assign oversize = src.rx_frame_end &&
        (src.rx_frame_bytes > `OVERSIZE_BYTES);

    // The enable mask lives elsewhere and is never consulted here.
    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[`BIT_SW] = rise[0];
        set_bits[`BIT_TX_HALT] = rise[1];
        set_bits[`BIT_RX_HALT] = rise[2];
        set_bits[`BIT_DROP_MID] = rise[3];
        set_bits[`BIT_TX_DONE] = src.tx_load_done &&
            src.completion_notify_flag;
        set_bits[`BIT_RX_DMA] = src.rx_dma_done;
        set_bits[`BIT_TIMER] = timer_wrap;
        set_bits[`BIT_POWER] = src.power_event;
        set_bits[`BIT_TX_SO] = src.tx_status_overflow;
        set_bits[`BIT_OVERSIZE] = oversize;
        set_bits[`BIT_RX_ERR] = src.rx_error;
        set_bits[`BIT_TX_ERR] = src.tx_error;
        set_bits[`BIT_TX_OVERRUN] = src.tx_data_write &&
            src.tx_data_full;
        set_bits[`BIT_TX_AVAIL] = rise[6];
        set_bits[`BIT_TS_FULL] = rise[4];
        set_bits[`BIT_TS_LEVEL] = rise[7];
        set_bits[`BIT_RX_DROP] = src.frame_dropped;
        set_bits[`BIT_RS_FULL] = rise[5];
        set_bits[`BIT_RS_LEVEL] = rise[8];
        set_bits[2:0] = src.pin_events;
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------

    logic [31:0] status_d;

    // The PHY event bit passes straight through with no hold-off.
    always_comb begin
        status_d = (interrupt_status & ~clear_bits) | set_bits;
        status_d[`BIT_PHY] = src.phy_event;
        status_d = status_d & ~`RESERVED_MASK;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_status <= `STATUS_RESET;
        end else begin
            interrupt_status <= status_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and wake request
    // ------------------------------------------------------------

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            host_rdata <= 32'h0000_0000;
        end else if (status_rd) begin
            host_rdata <= interrupt_status;
        end else begin
            host_rdata <= 32'h0000_0000;
        end
    end

    // A power event alone never raises this; only the host write does.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= wake_wr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    a_ack_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (status_wr && host_req.wdata[`BIT_RX_DMA] && !src.rx_dma_done)
        |=> !interrupt_status[`BIT_RX_DMA]
    ) else $error("flag not cleared by write of one");

    a_zero_keeps: assert property (
        @(posedge clk) disable iff (!nrst)
        (status_wr && !host_req.wdata[`BIT_TX_ERR] &&
         interrupt_status[`BIT_TX_ERR])
        |=> interrupt_status[`BIT_TX_ERR]
    ) else $error("write of zero cleared a flag");

    a_read_data: assert property (
        @(posedge clk) disable iff (!nrst)
        status_rd |=> host_rdata == $past(interrupt_status)
    ) else $error("read data does not match status");

    a_sw_set: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(src.software_event_enable) ##1 1'b1
        |-> interrupt_status[`BIT_SW]
    ) else $error("software flag did not set");

    a_tx_halt: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_stop_req && src.tx_halted && !cond_q[1])
        |=> interrupt_status[`BIT_TX_HALT]
    ) else $error("transmit halt flag did not set");

    a_drop_mid: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.drop_count[31] && !$past(src.drop_count[31]))
        |=> interrupt_status[`BIT_DROP_MID]
    ) else $error("drop counter midpoint flag did not set");

    a_timer_wrap: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.timer_value == 16'hffff && timer_q == 16'h0000)
        |=> interrupt_status[`BIT_TIMER]
    ) else $error("timer wrap flag did not set");

    a_phy_mirror: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 interrupt_status[`BIT_PHY] == $past(src.phy_event)
    ) else $error("transceiver bit does not mirror input");

    a_power_set: assert property (
        @(posedge clk) disable iff (!nrst)
        src.power_event |=> interrupt_status[`BIT_POWER] ##0 !wake_request
            or interrupt_status[`BIT_POWER]
    ) else $error("power event flag late or missing");

    a_wake_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wake_request |-> $past(wake_wr)
    ) else $error("wake raised without byte test write");

    a_oversize: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.rx_frame_end && src.rx_frame_bytes == 16'h0801)
        |=> interrupt_status[`BIT_OVERSIZE]
    ) else $error("oversize flag did not set");

    a_exact_size: assert property (
        @(posedge clk) disable iff (!nrst)
        (!interrupt_status[`BIT_OVERSIZE] && src.rx_frame_end &&
         src.rx_frame_bytes == 16'h0800)
        |=> !interrupt_status[`BIT_OVERSIZE]
    ) else $error("oversize flag set at exact limit");

    a_overrun: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_data_write && src.tx_data_full)
        |=> interrupt_status[`BIT_TX_OVERRUN]
    ) else $error("overrun flag did not set");

    a_reserved: assert property (
        @(posedge clk) disable iff (!nrst)
        (interrupt_status & 32'h7c40_1820) == 32'h0000_0000
    ) else $error("reserved status bit is set");

    a_set_wins: assert property (
        @(posedge clk) disable iff (!nrst)
        (status_wr && host_req.wdata[`BIT_RX_DROP] && src.frame_dropped)
        |=> interrupt_status[`BIT_RX_DROP]
    ) else $error("event lost in clearing cycle");

    a_pin_latch: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.pin_events[1] && !status_wr)
        |=> interrupt_status[1] [*2] or status_wr
    ) else $error("pin event not held");

    a_rx_halt: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.rx_halted && !$past(src.rx_halted))
        |=> interrupt_status[`BIT_RX_HALT]
    ) else $error("receive halt flag did not set");

    a_tx_done: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_load_done && src.completion_notify_flag)
        |=> interrupt_status[`BIT_TX_DONE]
    ) else $error("buffer done flag did not set");

    a_no_notify: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_load_done && !src.completion_notify_flag &&
         !interrupt_status[`BIT_TX_DONE])
        |=> !interrupt_status[`BIT_TX_DONE]
    ) else $error("buffer done flag set without notify");

    a_rx_dma: assert property (
        @(posedge clk) disable iff (!nrst)
        src.rx_dma_done |=> interrupt_status[`BIT_RX_DMA]
    ) else $error("receive DMA flag did not set");

    a_tx_so: assert property (
        @(posedge clk) disable iff (!nrst)
        src.tx_status_overflow |=> interrupt_status[`BIT_TX_SO]
    ) else $error("status overflow flag did not set");

    a_rx_error: assert property (
        @(posedge clk) disable iff (!nrst)
        src.rx_error |=> interrupt_status[`BIT_RX_ERR]
    ) else $error("receive error flag did not set");

    a_tx_error: assert property (
        @(posedge clk) disable iff (!nrst)
        src.tx_error |=> interrupt_status[`BIT_TX_ERR]
    ) else $error("transmit error flag did not set");

    a_space_avail: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_free_blocks > src.tx_avail_level &&
         $past(src.tx_free_blocks) <= $past(src.tx_avail_level))
        |=> interrupt_status[`BIT_TX_AVAIL]
    ) else $error("space available flag did not set");

    a_level_equal: assert property (
        @(posedge clk) disable iff (!nrst)
        (!interrupt_status[`BIT_TX_AVAIL] &&
         src.tx_free_blocks <= src.tx_avail_level)
        |=> !interrupt_status[`BIT_TX_AVAIL]
    ) else $error("space flag set without exceeding level");

    a_ts_full: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(src.tx_status_full) |=> interrupt_status[`BIT_TS_FULL]
    ) else $error("transmit status full flag did not set");

    a_rs_full: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(src.rx_status_full) |=> interrupt_status[`BIT_RS_FULL]
    ) else $error("receive status full flag did not set");

    a_ts_level: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.tx_status_used > src.tx_status_level &&
         $past(src.tx_status_used) <= $past(src.tx_status_level))
        |=> interrupt_status[`BIT_TS_LEVEL]
    ) else $error("transmit status level flag did not set");

    a_frame_drop: assert property (
        @(posedge clk) disable iff (!nrst)
        src.frame_dropped |=> interrupt_status[`BIT_RX_DROP]
    ) else $error("dropped frame flag did not set");

    a_pin_events: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.pin_events != 3'h0)
        |=> (interrupt_status[2:0] & $past(src.pin_events)) ==
            $past(src.pin_events)
    ) else $error("pin event flag did not set");

    a_wake_set: assert property (
        @(posedge clk) disable iff (!nrst)
        wake_wr |=> wake_request
    ) else $error("byte test write did not raise wake");

    a_power_no_wake: assert property (
        @(posedge clk) disable iff (!nrst)
        (src.power_event && !wake_wr) |=> !wake_request
    ) else $error("power event raised wake");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!nrst)
        !status_rd |=> host_rdata == 32'h0000_0000
    ) else $error("read data not zero outside a read");

endmodule

`default_nettype wire

// file: testbench/host_model.sv
// Host processor model: issues whole-word register reads and writes.
// Assumes the collector takes a request at the edge after it is driven.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import irq_status_pkg::*;
(
    input wire logic clk,               // System clock.
    input wire logic [31:0] host_rdata, // Read data from the collector.
    output var host_req_type host_req   // Request to the collector.
);
    // ----
    // Bus cycles
    // ----
    initial begin
        host_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 32'h0};
    end

    // Released address and data show the inverse, never a stale copy.
    task automatic write_word(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask

    task automatic read_word(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(posedge clk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hffffffff};
        // Read data stands for one cycle after the taking edge only.
        #1;
        d = host_rdata;
    endtask
endmodule

`default_nettype wire

// file: testbench/test_ethernet_irq_status_collector.sv
// Testbench for the interrupt status collector: each source in turn,
// boundaries, fixed bits, set-versus-clear race and the wake pulse.
// Assumes the host model and the collector share one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module test_ethernet_irq_status_collector
    import irq_status_pkg::*;
;
    // ----
    // Signals and instances
    // ----
    logic clk;
    logic nrst;
    host_req_type host_req;
    event_in_type src;
    event_in_type idle;
    logic [31:0] host_rdata;
    logic [31:0] interrupt_status;
    logic wake_request;
    int num_errors;
    int checks_done;
    int cycles;
    localparam int flag_bit [22] = '{31, 25, 24, 23, 21, 20, 19, 17, 16,
        15, 14, 13, 10, 9, 8, 7, 6, 4, 3, 0, 1, 2};

    host_model host (.clk(clk), .host_rdata(host_rdata),
        .host_req(host_req));
    ethernet_irq_status_collector dut (.clk(clk), .nrst(nrst),
        .host_req(host_req), .src(src), .host_rdata(host_rdata),
        .interrupt_status(interrupt_status),
        .wake_request(wake_request));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----
    // Scenarios
    // ----
    function automatic event_in_type stim(input int k);
        event_in_type e;
        e = idle;
        case (k)
            0: e.software_event_enable = 1'b1;
            1: e = '{default: '1};
            2: e.rx_halted = 1'b1;
            3: e.drop_count = 32'h8000_0000;
            4: e.tx_load_done = 1'b1;
            5: e.rx_dma_done = 1'b1;
            6: e.timer_value = 16'hffff;
            7: e.power_event = 1'b1;
            8: e.tx_status_overflow = 1'b1;
            9: e.rx_frame_bytes = 16'h0801;
            10: e.rx_error = 1'b1;
            11: e.tx_error = 1'b1;
            12: e.tx_data_write = 1'b1;
            13: e.tx_free_blocks = 8'h49;
            14: e.tx_status_full = 1'b1;
            15: e.tx_status_used = 8'h01;
            16: e.frame_dropped = 1'b1;
            17: e.rx_status_full = 1'b1;
            18: e.rx_status_used = 8'h01;
            default: e.pin_events = 3'(1 << (k - 19));
        endcase
        if (k == 1) begin
            e = idle;
            e.tx_stop_req = 1'b1;
            e.tx_halted = 1'b1;
        end
        e.completion_notify_flag = (k == 4);
        e.tx_data_full = (k == 12);
        e.rx_frame_end = (k == 9);
        return e;
    endfunction

    task automatic check_each_source();
        logic [31:0] exp;
        logic [31:0] rd;
        for (int k = 0; k < 22; k++) begin
            exp = 32'h1 << flag_bit[k];
            @(posedge clk);
            src <= stim(k);
            @(posedge clk);
            src <= idle;
            #1;
            `CHECK(interrupt_status, exp)
            host.read_word(8'h58, rd);
            `CHECK(rd, exp)
            host.write_word(8'h58, ~exp);
            `CHECK(interrupt_status, exp)
            host.write_word(8'h58, exp);
            `CHECK(interrupt_status, 32'h0)
        end
    endtask

    task automatic check_boundaries();
        event_in_type e;
        e = idle;
        e.rx_frame_end = 1'b1;
        e.rx_frame_bytes = 16'h0800;
        e.tx_free_blocks = 8'h48;
        e.tx_load_done = 1'b1;
        e.timer_value = 16'hfffe;
        @(posedge clk);
        src <= e;
        @(posedge clk);
        src <= idle;
        #1;
        `CHECK(interrupt_status, 32'h0)
    endtask

    task automatic check_fixed_bits();
        logic [31:0] rd;
        @(posedge clk);
        src.phy_event <= 1'b1;
        @(posedge clk);
        #1;
        `CHECK(interrupt_status, 32'h0004_0000)
        host.write_word(8'h58, 32'hffff_ffff);
        `CHECK(interrupt_status, 32'h0004_0000)
        host.read_word(8'h5c, rd);
        `CHECK(rd, 32'h0)
        @(posedge clk);
        src.phy_event <= 1'b0;
        @(posedge clk);
        #1;
        `CHECK(interrupt_status, 32'h0)
    endtask

    task automatic check_set_wins();
        @(posedge clk);
        src.power_event <= 1'b1;
        @(posedge clk);
        src.power_event <= 1'b0;
        #1;
        `CHECK(interrupt_status[17], 1'b1)
        `CHECK(wake_request, 1'b0)
        fork
            host.write_word(8'h58, 32'h0002_0040);
            begin
                @(posedge clk);
                src.power_event <= 1'b1;
                src.frame_dropped <= 1'b1;
                @(posedge clk);
                src.power_event <= 1'b0;
                src.frame_dropped <= 1'b0;
            end
        join
        `CHECK(interrupt_status[17], 1'b1)
        `CHECK(interrupt_status[6], 1'b1)
        host.write_word(8'h58, 32'h0002_0040);
        `CHECK(interrupt_status, 32'h0)
        host.write_word(8'h64, 32'h1234_5678);
        `CHECK(wake_request, 1'b1)
        @(posedge clk);
        #1;
        `CHECK(wake_request, 1'b0)
    endtask

    // Flags set in mid-run must vanish with reset and stay clear after it.
    task automatic check_reset();
        event_in_type e;
        e = idle;
        e.rx_error = 1'b1;
        e.pin_events = 3'h7;
        @(posedge clk);
        src <= e;
        @(posedge clk);
        src <= idle;
        #1;
        `CHECK(interrupt_status, 32'h0000_4007)
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        `CHECK(interrupt_status, 32'h0)
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        `CHECK(interrupt_status, 32'h0)
        `CHECK(host_rdata, 32'h0)
    endtask

    // ----
    // Run control
    // ----
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        idle = '0;
        idle.tx_avail_level = 8'h48;
        src = idle;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        `CHECK(interrupt_status, 32'h0)
        `CHECK(host_rdata, 32'h0)
        check_each_source();
        check_boundaries();
        check_fixed_bits();
        check_set_wins();
        check_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
